/* dv/mrd_ctrl_model.sv */
// Purpose: controller model driving the command pins on the link clock
// Assumes: each command launched 1 ns after a link clock rising edge
// Notes: released bank and address pins show the inverse of last value
`timescale 1ns/1ps
`include "mrd_defs.svh"
module mrd_ctrl_model (
   // link clock
   input wire logic ck_i,
   // command pins toward the device
   output logic cke_o,
   output logic cs_n_o,
   output logic ras_n_o,
   output logic cas_n_o,
   output logic we_n_o,
   output logic [2:0] ba_o,
   output logic [`MRD_MR_W-1:0] addr_o
);
   // idle pins at time zero, enable high until self refresh entry
   initial begin
      cke_o = 1'b1;
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hF;
      ba_o = 3'h0;
      addr_o = 14'h0000;
   end
   // one command for one link cycle, then deselect
   task automatic cmd(input logic [3:0] p, input logic [2:0] b,
      input logic [`MRD_MR_W-1:0] a);
      @(posedge ck_i);
      #1;
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} = p;
      ba_o = b;
      addr_o = a;
      @(posedge ck_i);
      #1;
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hF;
      ba_o = ~b; // released pins carry no stale value
      addr_o = ~a;
   endtask
   // second register, reserved bits forced low
   task automatic mrs1(input logic [`MRD_MR_W-1:0] a);
      cmd(4'h0, `MRD_BA_MR1, a & 14'h1AFF);
   endtask
   // first register, top bit forced low
   task automatic mr0(input logic [`MRD_MR_W-1:0] a);
      cmd(4'h0, `MRD_BA_MR0, a & 14'h1FFF);
   endtask
   // self refresh entry: enable drops with the refresh pattern
   task automatic sref_in();
      @(posedge ck_i);
      #1;
      cke_o = 1'b0;
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'h1;
      @(posedge ck_i);
      #1;
      {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hF;
   endtask
   // self refresh exit, enable stays high while relocking
   task automatic sref_out();
      @(posedge ck_i);
      #1;
      cke_o = 1'b1;
   endtask
endmodule // mrd_ctrl_model

/* dv/mrd_top_checker.sv */
// Purpose: port checks for the mode register one decode block
// Assumes: bound onto mrd_top, watches its ports only
// Notes: link rules on ck_i, decoded fields on clk_i
`timescale 1ns/1ps
`include "mrd_defs.svh"
module mrd_top_checker (
   // clocks and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic ck_i,
   // command pins
   input wire logic cke_i,
   input wire logic cs_n_i,
   input wire logic ras_n_i,
   input wire logic cas_n_i,
   input wire logic we_n_i,
   input wire logic [2:0] ba_i,
   input wire logic [`MRD_MR_W-1:0] addr_i,
   input wire logic dyn_odt_en_i,
   // link side outputs
   input wire logic int_rd_o,
   input wire logic wr_term_ok_o,
   input wire logic dll_run_o,
   input wire logic dll_locked_o,
   // decoded outputs
   input wire logic [`MRD_LAT_W-1:0] drive_div_o,
   input wire logic drive_rsvd_o,
   input wire logic [`MRD_LAT_W-1:0] term_div_o,
   input wire logic term_rsvd_o,
   input wire logic term_write_ok_o,
   input wire logic [1:0] posted_code_o,
   input wire logic posted_rsvd_o,
   input wire logic wlevel_o,
   input wire logic dq_out_en_o
);
   logic cke_q; // enable at the previous edge
   logic [9:0] unlock_cnt; // edges without lock, saturating
   logic [3:0] rd_age; // edges since the last taken read
   wire take = cke_i & cke_q & ~cs_n_i;
   wire rd_cmd = take & ras_n_i & ~cas_n_i & we_n_i;
   // helper counters; saturation keeps old history harmless
   always_ff @(posedge ck_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cke_q <= 1'b0;
         unlock_cnt <= 10'h000;
         rd_age <= 4'hF;
      end else begin
         cke_q <= cke_i;
         unlock_cnt <= dll_locked_o ? 10'h000 :
            unlock_cnt + {9'h000, ~&unlock_cnt};
         rd_age <= rd_cmd ? 4'h0 : rd_age + {3'h0, ~&rd_age};
      end
   end
   // second register load that switches the loop off
   sequence s_loop_off_load;
      take & ~ras_n_i & ~cas_n_i & ~we_n_i & (ba_i == `MRD_BA_MR1)
         & addr_i[0];
   endsequence
   // self refresh entry while the loop holds lock
   sequence s_sref_entry;
      ~cke_i & cke_q & ~cs_n_i & ~ras_n_i & ~cas_n_i & we_n_i
         & dll_locked_o;
   endsequence
   a_load_stops_loop: assert property (
      @(posedge ck_i) disable iff (!rstn_i)
      s_loop_off_load |-> ##2 (!dll_run_o && !dll_locked_o))
      else $error("loop still running after disable load");
   a_sref_stops_loop: assert property (
      @(posedge ck_i) disable iff (!rstn_i)
      s_sref_entry |=> (!dll_run_o && !dll_locked_o))
      else $error("loop still running in self refresh");
   a_lock_wait_full: assert property (
      @(posedge ck_i) disable iff (!rstn_i)
      $rose(dll_locked_o) |-> unlock_cnt > 10'h200)
      else $error("lock reported before lock time");
   a_write_gate_ok: assert property (
      @(posedge ck_i) disable iff (!rstn_i)
      wr_term_ok_o == (!dyn_odt_en_i || dll_locked_o))
      else $error("write gate does not follow lock");
   a_read_has_cause: assert property (
      @(posedge ck_i) disable iff (!rstn_i)
      int_rd_o |-> rd_age != 4'hF)
      else $error("internal read without external read");
   a_drive_codes: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      drive_rsvd_o ? drive_div_o == 4'h0
         : drive_div_o inside {4'h0, 4'h6, 4'h7})
      else $error("drive divisor outside legal set");
   a_term_reserved: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      term_rsvd_o |-> term_div_o == 4'h0)
      else $error("reserved termination gives a divisor");
   a_term_write_ok: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      term_write_ok_o == (term_div_o inside {4'h2, 4'h4, 4'h6}
         || wlevel_o && !dq_out_en_o))
      else $error("write termination flag wrong");
   a_posted_reserved: assert property (
      @(posedge clk_i) disable iff (!rstn_i)
      posted_rsvd_o == (posted_code_o == 2'h3))
      else $error("posted latency reserved flag wrong");
endmodule // mrd_top_checker

/* dv/tb_ddr3_mode_register_one_decode.sv */
// Purpose: self-checking bench for the mode register one decode block
// Assumes: controller model drives the link pins on ck_i
// Notes: lock waits lean on the fixed 512 cycle lock count
`timescale 1ns/1ps
`include "mrd_defs.svh"
module tb_ddr3_mode_register_one_decode;
   logic clk_i = 1'b0; // system clock
   logic ck_i = 1'b0; // link clock
   logic rstn_i = 1'b0;
   logic dyn_odt_en_i = 1'b0;
   logic cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i;
   logic [2:0] ba_i;
   logic [`MRD_MR_W-1:0] addr_i;
   logic int_rd_o, int_wr_o, wr_term_ok_o, dll_run_o, dll_locked_o;
   logic dll_enabled_o, drive_rsvd_o, term_rsvd_o, term_write_ok_o;
   logic posted_rsvd_o, wlevel_o, termination_strobe_enable_en_o, dq_out_en_o;
   logic [`MRD_LAT_W-1:0] drive_div_o, term_div_o;
   logic [1:0] posted_code_o;
   integer seed = 32'he04e835f;
   integer miscompares = 0;
   integer n_checks = 0;
   integer i, n;
   logic [`MRD_MR_W-1:0] a;
   logic [2:0] c;
   initial forever #2.5 clk_i = ~clk_i;
   // link clock with a phase unrelated to clk_i
   initial begin
      #1.3;
      forever #7.5 ck_i = ~ck_i;
   end
   mrd_top dut (.*);
   mrd_ctrl_model m (.ck_i(ck_i), .cke_o(cke_i), .cs_n_o(cs_n_i),
      .ras_n_o(ras_n_i), .cas_n_o(cas_n_i), .we_n_o(we_n_i),
      .ba_o(ba_i), .addr_o(addr_i));
   // compare helpers
   task automatic chk_val(input logic [3:0] g, input logic [3:0] e);
      n_checks++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chk_bit(input logic g, input logic e);
      chk_val({3'h0, g}, {3'h0, e});
   endtask
   // expected decodes
   function automatic logic [3:0] exp_drive(input logic [1:0] d);
      return d == 2'h0 ? 4'h6 : d == 2'h1 ? 4'h7 : 4'h0;
   endfunction
   function automatic logic [3:0] exp_term(input logic [2:0] t);
      case (t)
         3'h1: return 4'h4;
         3'h2: return 4'h2;
         3'h3: return 4'h6;
         3'h4: return 4'hC;
         3'h5: return 4'h8;
         default: return 4'h0;
      endcase
   endfunction
   // posted latency from its code and the read latency code
   function automatic logic [3:0] exp_al(input logic [1:0] p,
      input logic [2:0] r);
      return p == 2'h1 ? 4'h3 + r : p == 2'h2 ? 4'h2 + r : 4'h0;
   endfunction
   // termination fit for writes, or anything while leveling unheard
   function automatic logic exp_wok(input logic [`MRD_MR_W-1:0] v);
      return exp_term({v[9], v[6], v[2]}) inside {4'h2, 4'h4, 4'h6}
         || (v[7] && v[12]);
   endfunction
   // load the second register, let it cross, check every field
   task automatic mr1_check(input logic [`MRD_MR_W-1:0] v);
      m.mrs1(v);
      repeat (12) @(posedge ck_i);
      chk_bit(dll_enabled_o, ~v[0]);
      chk_val(drive_div_o, exp_drive({v[5], v[1]}));
      chk_bit(drive_rsvd_o, v[5]);
      chk_val(term_div_o, exp_term({v[9], v[6], v[2]}));
      chk_bit(term_rsvd_o, v[9] & v[6]);
      chk_bit(term_write_ok_o, exp_wok(v));
      chk_val({2'h0, posted_code_o}, {2'h0, v[4:3]});
      chk_bit(posted_rsvd_o, v[4] & v[3]);
      chk_bit(wlevel_o, v[7]);
      chk_bit(termination_strobe_enable_en_o, v[11]);
      chk_bit(dq_out_en_o, ~v[12]);
   endtask
   // launch a read or write, count edges from the taking edge until
   // the internal pulse stands; zero latency shows it at once
   task automatic timed(input logic [3:0] p, output integer k);
      m.cmd(p, 3'($random(seed)), 14'($random(seed)));
      k = 0;
      while ((p[0] ? int_rd_o : int_wr_o) !== 1'b1 && k < 20) begin
         @(posedge ck_i);
         #1;
         k++;
      end
   endtask
   // single exit point of the run
   task automatic tally_and_finish();
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // hang guard, far beyond the expected 26 us
   initial begin
      #80000;
      miscompares++;
      tally_and_finish();
   end
   initial begin
      repeat (3) @(posedge ck_i);
      #1;
      rstn_i = 1'b1;
      repeat (3) @(posedge ck_i);
      #1;
      chk_bit(dll_enabled_o, 1'b1);
      chk_val(drive_div_o, 4'h6);
      chk_bit(dq_out_en_o, 1'b1);
      // every drive and termination code, other bits random
      for (i = 0; i < 32; i++) begin
         a = (14'($random(seed)) & 14'h3D99) | {4'h0, i[4], 2'h0,
            i[3], i[1], 2'h0, i[2], i[0], 1'h0};
         mr1_check(a);
      end
      mr1_check(14'h0000);
      m.mr0(14'h0100);
      dyn_odt_en_i = 1'b1;
      repeat (500) @(posedge ck_i);
      #1;
      chk_bit(dll_locked_o, 1'b0);
      chk_bit(wr_term_ok_o, 1'b0);
      repeat (20) @(posedge ck_i);
      #1;
      chk_bit(dll_locked_o, 1'b1);
      chk_bit(wr_term_ok_o, 1'b1);
      m.sref_in();
      repeat (2) @(posedge ck_i);
      #1;
      chk_bit(dll_run_o, 1'b0);
      chk_bit(dll_locked_o, 1'b0);
      m.sref_out();
      repeat (505) @(posedge ck_i);
      #1;
      chk_bit(dll_locked_o, 1'b0);
      repeat (15) @(posedge ck_i);
      #1;
      chk_bit(dll_locked_o, 1'b1);
      chk_bit(dll_run_o, 1'b1);
      // each posted latency code against a random read latency
      for (i = 0; i < 4; i++) begin
         c = 3'($random(seed));
         m.mr0({7'h00, c, 4'h0});
         repeat (8) @(posedge ck_i);
         m.mrs1({9'h000, i[1:0], 3'h0});
         repeat (8) @(posedge ck_i);
         timed(4'h5, n);
         chk_val(4'(n), exp_al(i[1:0], c));
         repeat (12) @(posedge ck_i);
         timed(4'h4, n);
         chk_val(4'(n), exp_al(i[1:0], c));
         repeat (12) @(posedge ck_i);
      end
      mr1_check(14'h0001);
      chk_bit(dll_run_o, 1'b0);
      tally_and_finish();
   end
endmodule // tb_ddr3_mode_register_one_decode
bind mrd_top mrd_top_checker chk (.*);

/* hw/mrd_al_delay.sv */
// Purpose: hold external read and write commands for the posted latency
// Assumes: runs on the link clock, latency stable between commands
// Notes: output register is part of the programmed latency, no extra stage
`timescale 1ns/1ps
`include "mrd_defs.svh"

module mrd_al_delay (
   // link clock and reset
   input wire logic ck_i,
   input wire logic rstn_i,
   // commands in
   input wire logic rd_i,
   input wire logic wr_i,
   input wire logic [`MRD_LAT_W-1:0] lat_i,
   // delayed internal commands
   output logic rd_o,
   output logic wr_o
);
   logic [1:0] cmd_in; // channel 0 read, channel 1 write
   logic [1:0] cmd_out; // delayed copies
   assign cmd_in = {wr_i, rd_i};
   assign rd_o = cmd_out[0];
   assign wr_o = cmd_out[1];

   // one shift line per channel
   for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      logic [`MRD_AL_DEPTH-1:0] line; // command history
      logic tap; // selected history bit
      // zero latency bypasses the line entirely
      assign tap = (lat_i == `MRD_LAT_ZERO) ? cmd_in[ch] :
                   line[lat_i - `MRD_LAT_ONE];
      // shift history and register the tap
      always_ff @(posedge ck_i or negedge rstn_i) begin
         if (!rstn_i) begin
            line <= '0;
            cmd_out[ch] <= 1'b0;
         end else begin
            line <= {line[`MRD_AL_DEPTH-2:0], cmd_in[ch]};
            cmd_out[ch] <= tap;
         end
      end
   end
endmodule // mrd_al_delay

/* hw/mrd_defs.svh */
// Purpose: shared constants for the mode register one decode block
// Assumes: included by bare name from every design file that needs it
// Notes: bit positions refer to the address pins captured at load time
`ifndef MRD_DEFS_SVH
`define MRD_DEFS_SVH

// bank address codes of the mode register set command
`define MRD_BA_MR0 3'h0
`define MRD_BA_MR1 3'h1

// field positions inside the second mode register
`define MRD_B_DLL_OFF 0
`define MRD_B_DS_LO 1
`define MRD_B_TN_LO 2
`define MRD_B_AL_LO 3
`define MRD_B_AL_HI 4
`define MRD_B_DS_HI 5
`define MRD_B_TN_MID 6
`define MRD_B_WLEV 7
`define MRD_B_TN_HI 9
`define MRD_B_TERMINATION_STROBE_ENABLE 11
`define MRD_B_QOFF 12

// field positions inside the first mode register
`define MRD_B_CL0 2
`define MRD_B_CL_LO 4
`define MRD_B_CL_HI 6
`define MRD_B_DLL_RST 8

// widths
`define MRD_MR_W 14
`define MRD_LAT_W 4
`define MRD_AL_DEPTH 16

// drive strength codes and divisors
`define MRD_DS_6 2'h0
`define MRD_DS_7 2'h1
`define MRD_DIV_0 4'h0
`define MRD_DIV_2 4'h2
`define MRD_DIV_4 4'h4
`define MRD_DIV_6 4'h6
`define MRD_DIV_7 4'h7
`define MRD_DIV_8 4'h8
`define MRD_DIV_12 4'hC

// nominal termination codes
`define MRD_TN_OFF 3'h0
`define MRD_TN_4 3'h1
`define MRD_TN_2 3'h2
`define MRD_TN_6 3'h3
`define MRD_TN_12 3'h4
`define MRD_TN_8 3'h5

// posted latency codes
`define MRD_AL_ZERO 2'h0
`define MRD_AL_CLM1 2'h1
`define MRD_AL_CLM2 2'h2
`define MRD_LAT_ZERO 4'h0
`define MRD_LAT_ONE 4'h1
`define MRD_LAT_TWO 4'h2
`define MRD_CL_BASE 4'h4

// delay loop lock time in link clock cycles
`define MRD_LOCK_CYCLES 10'h200
`define MRD_LOCK_W 10
`define MRD_CNT_ONE 10'h001

`endif

/* hw/mrd_pkg.sv */
// Purpose: types shared by the mode register one decode block
// Assumes: nothing beyond the constants header
// Notes: only the delay loop state lives here
package mrd_pkg;
   // delay loop state as seen from the command side
   typedef enum logic [1:0] {
      MRD_DLL_IDLE,
      MRD_DLL_LOCKING,
      MRD_DLL_LOCKED,
      MRD_DLL_SREF
   } mrd_dll_e;
endpackage

/* hw/mrd_top.sv */
// Purpose: capture and decode the second mode register and run the
//          delay loop bookkeeping that its fields steer
// Assumes: command pins are sampled on the link clock ck_i
// Notes: the register image is carried into clk_i by a toggle synchroniser and decoded there
// What this block does
// - load register on set command, bank 001
// - self refresh stops a locking or locked loop, exit resets it
// - writes need lock only with dynamic termination
// - drive code 00 is over 6, 01 over 7
// - termination 000 off, 001 over 4, 010 over 2
// - termination 100 over 12, 101 over 8
// - commands held for posted latency first
// - latency 00 zero, 01 cl-1, 10 cl-2
// - bit 7 selects write leveling mode
// - bit 12 disables data and strobe outputs
// - loop reset bit clears itself one edge later unless the loop is in self refresh
`timescale 1ns/1ps
`include "mrd_defs.svh"

module mrd_top (
   // system clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // link clock
   input wire logic ck_i,
   // command pins, link clock domain
   input wire logic cke_i,
   input wire logic cs_n_i,
   input wire logic ras_n_i,
   input wire logic cas_n_i,
   input wire logic we_n_i,
   input wire logic [2:0] ba_i,
   input wire logic [`MRD_MR_W-1:0] addr_i,
   input wire logic dyn_odt_en_i,
   // internal commands, write gate and loop status, link clock domain
   output logic int_rd_o,
   output logic int_wr_o,
   output logic wr_term_ok_o,
   output logic dll_run_o,
   output logic dll_locked_o,
   // decoded fields, system clock domain
   output logic dll_enabled_o,
   output logic [`MRD_LAT_W-1:0] drive_div_o,
   output logic drive_rsvd_o,
   output logic [`MRD_LAT_W-1:0] term_div_o,
   output logic term_rsvd_o,
   output logic term_write_ok_o,
   output logic [1:0] posted_code_o,
   output logic posted_rsvd_o,
   output logic wlevel_o,
   output logic termination_strobe_enable_en_o,
   output logic dq_out_en_o
);
   // reset release, one pair per domain
   logic [1:0] rs_clk; // system side release chain
   logic [1:0] rs_ck; // link side release chain
   logic rst_n; // system side reset
   logic ck_rst_n; // link side reset
   assign rst_n = rs_clk[1];
   assign ck_rst_n = rs_ck[1];

   // release chain on the system clock
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) rs_clk <= 2'h0;
      else rs_clk <= {rs_clk[0], 1'b1};
   end

   // release chain on the link clock
   always_ff @(posedge ck_i or negedge rstn_i) begin
      if (!rstn_i) rs_ck <= 2'h0;
      else rs_ck <= {rs_ck[0], 1'b1};
   end

   // command decode, link side
   logic cke_q; // clock enable of the previous edge
   logic cmd_ok; // command sampled with clock enable held high
   logic is_mrs; // mode register set
   logic is_ref; // refresh pattern, self refresh when cke falls
   logic is_rd; // external read
   logic is_wr; // external write
   logic ld_mr1; // load second mode register
   logic ld_mr0; // load first mode register fields we need
   assign cmd_ok = cke_q & cke_i & ~cs_n_i;
   assign is_mrs = cmd_ok & ~ras_n_i & ~cas_n_i & ~we_n_i;
   assign is_ref = ~cs_n_i & ~ras_n_i & ~cas_n_i & we_n_i;
   assign is_rd = cmd_ok & ras_n_i & ~cas_n_i & we_n_i;
   assign is_wr = cmd_ok & ras_n_i & ~cas_n_i & ~we_n_i;
   assign ld_mr1 = is_mrs & (ba_i == `MRD_BA_MR1);
   assign ld_mr0 = is_mrs & (ba_i == `MRD_BA_MR0);

   // captured registers, link side
   logic [`MRD_MR_W-1:0] second_mode_register; // whole field image
   logic [3:0] read_latency_code; // first register latency bits
   logic delay_loop_reset_bit; // pending reset request
   logic mr1_tog; // flips on every second register load
   mrd_pkg::mrd_dll_e dll_st; // delay loop state
   mrd_pkg::mrd_dll_e next_dll_st; // its next value
   logic [`MRD_LOCK_W-1:0] lock_cnt; // remaining lock cycles
   logic [`MRD_LOCK_W-1:0] next_lock_cnt; // its next value
   logic delay_loop_off_bit; // loop disabled by software
   logic sr_entry; // clock enable falls on refresh
   logic sr_exit; // clock enable returns in self refresh
   assign delay_loop_off_bit = second_mode_register[`MRD_B_DLL_OFF];
   assign sr_entry = cke_q & ~cke_i & is_ref;
   assign sr_exit = (dll_st == mrd_pkg::MRD_DLL_SREF) & cke_i;

   // register loads; reset image chosen as all zero, loop enabled
   always_ff @(posedge ck_i or negedge ck_rst_n) begin
      if (!ck_rst_n) begin
         cke_q <= 1'b0;
         second_mode_register <= '0;
         read_latency_code <= 4'h0;
         mr1_tog <= 1'b0;
      end else begin
         cke_q <= cke_i;
         if (ld_mr1) begin
            second_mode_register <= addr_i;
            mr1_tog <= ~mr1_tog;
         end
         if (ld_mr0) begin
            read_latency_code <= {addr_i[`MRD_B_CL_HI:`MRD_B_CL_LO],
                                  addr_i[`MRD_B_CL0]};
         end
      end
   end

   // reset bit sets on request and clears at the next edge unless the loop sits in self refresh
   always_ff @(posedge ck_i or negedge ck_rst_n) begin
      if (!ck_rst_n) delay_loop_reset_bit <= 1'b0;
      else if (ld_mr0 && addr_i[`MRD_B_DLL_RST])
         delay_loop_reset_bit <= 1'b1; // a new request wins
      else if (dll_st != mrd_pkg::MRD_DLL_SREF)
         delay_loop_reset_bit <= 1'b0;
   end

   // delay loop state and lock countdown
   always_comb begin
      next_dll_st = dll_st;
      next_lock_cnt = lock_cnt;
      case (dll_st)
         mrd_pkg::MRD_DLL_IDLE: begin
            // an enabled loop only starts counting after a reset
            if (delay_loop_reset_bit) begin
               next_dll_st = mrd_pkg::MRD_DLL_LOCKING;
               next_lock_cnt = `MRD_LOCK_CYCLES;
            end
         end
         mrd_pkg::MRD_DLL_LOCKING: begin
            if (sr_entry) next_dll_st = mrd_pkg::MRD_DLL_SREF;
            else if (delay_loop_reset_bit)
               next_lock_cnt = `MRD_LOCK_CYCLES;
            else if (lock_cnt == `MRD_LOCK_W'(0))
               next_dll_st = mrd_pkg::MRD_DLL_LOCKED;
            else if (cke_i) // pauses if the controller drops enable
               next_lock_cnt = lock_cnt - `MRD_CNT_ONE;
         end
         mrd_pkg::MRD_DLL_LOCKED: begin
            if (sr_entry) next_dll_st = mrd_pkg::MRD_DLL_SREF;
            else if (delay_loop_reset_bit) begin
               next_dll_st = mrd_pkg::MRD_DLL_LOCKING;
               next_lock_cnt = `MRD_LOCK_CYCLES;
            end
         end
         mrd_pkg::MRD_DLL_SREF: begin
            // exit re-enables and resets the loop on its own
            if (sr_exit) begin
               next_dll_st = mrd_pkg::MRD_DLL_LOCKING;
               next_lock_cnt = `MRD_LOCK_CYCLES;
            end
         end
         default: next_dll_st = mrd_pkg::MRD_DLL_IDLE;
      endcase
      // software disable overrides everything
      if (delay_loop_off_bit) next_dll_st = mrd_pkg::MRD_DLL_IDLE;
   end

   // state registers
   always_ff @(posedge ck_i or negedge ck_rst_n) begin
      if (!ck_rst_n) begin
         dll_st <= mrd_pkg::MRD_DLL_IDLE;
         lock_cnt <= '0;
      end else begin
         dll_st <= next_dll_st;
         lock_cnt <= next_lock_cnt;
      end
   end

   // link side status
   logic [`MRD_LAT_W-1:0] read_latency; // decoded from first register
   logic [`MRD_LAT_W-1:0] posted_command_latency; // programmed delay
   logic [1:0] al_code; // raw latency code
   assign al_code = second_mode_register[`MRD_B_AL_HI:`MRD_B_AL_LO];
   assign read_latency = `MRD_CL_BASE + {1'b0, read_latency_code[3:1]};
   assign posted_command_latency =
      (al_code == `MRD_AL_CLM1) ? read_latency - `MRD_LAT_ONE :
      (al_code == `MRD_AL_CLM2) ? read_latency - `MRD_LAT_TWO :
      `MRD_LAT_ZERO; // zero code and reserved code both give no delay
   assign dll_locked_o = (dll_st == mrd_pkg::MRD_DLL_LOCKED);
   assign dll_run_o = ~delay_loop_off_bit &
                      (dll_st != mrd_pkg::MRD_DLL_SREF);
   // writes need the loop only for dynamic termination
   assign wr_term_ok_o = ~dyn_odt_en_i | dll_locked_o;

   // external to internal command delay
   mrd_al_delay u_al_delay (
      .ck_i(ck_i),
      .rstn_i(ck_rst_n),
      .rd_i(is_rd),
      .wr_i(is_wr),
      .lat_i(posted_command_latency),
      .rd_o(int_rd_o),
      .wr_o(int_wr_o)
   );

   // crossing: toggle synchroniser, image is stable long before the
   // toggle lands since loads are spaced many link cycles apart
   logic [2:0] tog_sync; // two sync stages then an edge history
   logic [`MRD_MR_W-1:0] mr_img; // system side copy
   logic new_img; // toggle edge seen
   assign new_img = tog_sync[1] ^ tog_sync[2];

   // synchroniser and capture
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         tog_sync <= 3'h0;
         mr_img <= '0;
      end else begin
         tog_sync <= {tog_sync[1:0], mr1_tog};
         if (new_img) mr_img <= second_mode_register;
      end
   end

   // field decode, system side
   logic [1:0] drive_strength_sel; // drive code
   logic [2:0] term_code; // nominal termination code
   logic [`MRD_LAT_W-1:0] next_drive_div; // drive divisor
   logic [`MRD_LAT_W-1:0] next_term_div; // termination divisor
   logic next_term_rsvd; // unlisted termination code
   logic next_term_write_ok; // setting legal under writes or leveling
   assign drive_strength_sel = {mr_img[`MRD_B_DS_HI], mr_img[`MRD_B_DS_LO]};
   assign term_code = {mr_img[`MRD_B_TN_HI], mr_img[`MRD_B_TN_MID],
                       mr_img[`MRD_B_TN_LO]};
   assign next_drive_div =
      (drive_strength_sel == `MRD_DS_6) ? `MRD_DIV_6 :
      (drive_strength_sel == `MRD_DS_7) ? `MRD_DIV_7 :
      `MRD_DIV_0;

   // termination lookup
   always_comb begin
      next_term_rsvd = 1'b0;
      case (term_code)
         `MRD_TN_OFF: next_term_div = `MRD_DIV_0;
         `MRD_TN_4: next_term_div = `MRD_DIV_4;
         `MRD_TN_2: next_term_div = `MRD_DIV_2;
         `MRD_TN_6: next_term_div = `MRD_DIV_6;
         `MRD_TN_12: next_term_div = `MRD_DIV_12;
         `MRD_TN_8: next_term_div = `MRD_DIV_8;
         default: begin
            next_term_div = `MRD_DIV_0; // reserved reads as off
            next_term_rsvd = 1'b1;
         end
      endcase
   end

   // flags whether the setting suits writes; leveling with outputs
   // off allows anything, informational only
   assign next_term_write_ok = (mr_img[`MRD_B_WLEV] & mr_img[`MRD_B_QOFF])
      | (next_term_div == `MRD_DIV_2) | (next_term_div == `MRD_DIV_4)
      | (next_term_div == `MRD_DIV_6);

   // registered decoded outputs
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         dll_enabled_o <= 1'b0;
         drive_div_o <= '0;
         drive_rsvd_o <= 1'b0;
         term_div_o <= '0;
         term_rsvd_o <= 1'b0;
         term_write_ok_o <= 1'b0;
         posted_code_o <= 2'h0;
         posted_rsvd_o <= 1'b0;
         wlevel_o <= 1'b0;
         termination_strobe_enable_en_o <= 1'b0;
         dq_out_en_o <= 1'b0;
      end else begin
         dll_enabled_o <= ~mr_img[`MRD_B_DLL_OFF];
         drive_div_o <= next_drive_div;
         drive_rsvd_o <= (next_drive_div == `MRD_DIV_0);
         term_div_o <= next_term_div;
         term_rsvd_o <= next_term_rsvd;
         term_write_ok_o <= next_term_write_ok;
         posted_code_o <= mr_img[`MRD_B_AL_HI:`MRD_B_AL_LO];
         posted_rsvd_o <= &mr_img[`MRD_B_AL_HI:`MRD_B_AL_LO];
         wlevel_o <= mr_img[`MRD_B_WLEV];
         termination_strobe_enable_en_o <= mr_img[`MRD_B_TERMINATION_STROBE_ENABLE];
         dq_out_en_o <= ~mr_img[`MRD_B_QOFF];
      end
   end
endmodule // mrd_top
